// file: core/ism_defines.svh
// constants for the io signal switch matrix
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH
`define ISM_NSRC 25
`define ISM_NDST 18
`define ISM_SELW 5
`define ISM_SRC_IN0 5'h00
`define ISM_SRC_RXD 5'h04
`define ISM_SRC_TXU1 5'h05
`define ISM_SRC_PG0 5'h06
`define ISM_SRC_PG1 5'h07
`define ISM_SRC_PWMA 5'h08
`define ISM_SRC_PWMB 5'h09
`define ISM_SRC_EXPOSE 5'h0A
`define ISM_SRC_READOUT 5'h0B
`define ISM_SRC_SEQPULSE 5'h0C
`define ISM_SRC_PWMC 5'h0D
`define ISM_SRC_PWMD 5'h0E
`define ISM_SRC_SEQACT 5'h0F
`define ISM_SRC_DEB 5'h10
`define ISM_SRC_DIV 5'h11
`define ISM_SRC_PWMMASK 5'h12
`define ISM_SRC_LOGIC 5'h13
`define ISM_SRC_PG2 5'h14
`define ISM_SRC_PG3 5'h15
`define ISM_SRC_MFTRXD 5'h16
`define ISM_SRC_TRIGFB 5'h17
`define ISM_SRC_TXU2 5'h18
`define ISM_DST_SEQTRIG 7
`define ISM_DST_DEB 8
`define ISM_DST_DIV 9
`define ISM_DST_LOGA 10
`define ISM_DST_LOGB 11
`define ISM_DST_PG0 13
`define ISM_DEF_SEL 5'h00
`define ISM_LOG_AND 2'h0
`define ISM_LOG_OR 2'h1
`define ISM_LOG_XOR 2'h2
`define ISM_LOG_NAND 2'h3
`endif

// file: core/ism_pkg.sv
// types for the io signal switch matrix
package ism_pkg;
    // per-line conditioning options
    typedef struct packed {
        logic inv;
        logic force_hi;
    } ism_lineopt_s;
    // one destination's configuration
    typedef struct packed {
        logic [4:0] sel;
        ism_lineopt_s opt;
    } ism_route_s;
    // non-volatile store handshake
    typedef enum logic [3:0] {
        ISM_ST_LOAD = 4'h1,
        ISM_ST_WAIT = 4'h2,
        ISM_ST_RUN = 4'h4,
        ISM_ST_SAVE = 4'h8
    } ism_state_e;
endpackage : ism_pkg

// file: core/ism_switch_matrix.sv
// io signal switch matrix with persistent routing
`timescale 1ns/1ps
`include "ism_defines.svh"
module ism_switch_matrix #(
    parameter int NSRC = `ISM_NSRC,
    parameter int NDST = `ISM_NDST
) (
    input wire logic mclk,
    input wire logic arst_n,
    // physical pins: 3-stage synchronised
    input wire logic [3:0] pin_trig_in,
    input wire logic pin_rxd,
    input wire logic pin_mft_rxd,
    // same-clock sources from function modules
    input wire logic [NSRC-1:0] mod_src,
    // configuration port
    input wire logic cfg_we,
    input wire logic [4:0] cfg_dst,
    input wire ism_pkg::ism_route_s cfg_route,
    input wire logic [4:0] cfg_src_idx,
    input wire ism_pkg::ism_lineopt_s cfg_src_opt,
    input wire logic cfg_src_we,
    input wire logic [1:0] cfg_log_op,
    input wire logic cmd_default,
    input wire logic cmd_save,
    // non-volatile store
    input wire logic nv_valid,
    input wire logic nv_rd_done,
    input wire ism_pkg::ism_route_s [NDST-1:0] nv_rd_data,
    output logic nv_rd_req,
    output logic nv_wr_req,
    output ism_pkg::ism_route_s [NDST-1:0] nv_wr_data,
    input wire logic nv_wr_done,
    // outputs
    output logic [NDST-1:0] dst_out,
    output logic [3:0] pin_od_oe_n,
    output logic logic_result,
    output logic cfg_busy
);
    // synchroniser chain for the six pin inputs
    logic [5:0] s1_q, s2_q, s3_q, pin_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
            pin_q <= 6'h00;
        end else begin
            s1_q <= {pin_mft_rxd, pin_rxd, pin_trig_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // accept a change only when stages agree
            pin_q <= pin_q ^ ((s2_q ~^ s3_q) & (s2_q ^ pin_q));
        end
    end

    // function modules fed from their own slots, pins and the logic result overlay theirs
    logic log_res_q;
    logic [NSRC-1:0] src_raw;
    assign src_raw = {mod_src[NSRC-1:23], pin_q[5], mod_src[21:20],
        log_res_q, mod_src[18:5], pin_q[4], pin_q[3:0]};

    // conditioning function shared by sources and destinations
    function automatic logic cond(input logic v, input ism_pkg::ism_lineopt_s o);
        cond = (o.force_hi ? 1'b1 : v) ^ o.inv;
    endfunction : cond

    ism_pkg::ism_lineopt_s src_opt_q [NSRC];
    logic [NSRC-1:0] src_c;
    genvar gs;
    generate
        for (gs = 0; gs < NSRC; gs++) begin : g_src
            assign src_c[gs] = cond(src_raw[gs], src_opt_q[gs]);
        end
    endgenerate

    // routing table
    ism_pkg::ism_route_s route_q [NDST];
    ism_pkg::ism_state_e st_q;
    logic [NDST-1:0] pre_out;
    logic [NDST-1:0] sel_ok; // select names an existing source
    logic [NDST-1:0] sel_raw; // selected source before destination options
    generate
        for (gs = 0; gs < NDST; gs++) begin : g_dst
            // invalid select reads low, yet force and inversion still apply
            assign sel_ok[gs] = (route_q[gs].sel < 5'(NSRC));
            assign sel_raw[gs] = sel_ok[gs] ? src_c[route_q[gs].sel] : 1'b0;
            assign pre_out[gs] = cond(sel_raw[gs], route_q[gs].opt);
        end
    endgenerate

    // boolean unit on operand destinations
    logic log_d;
    always_comb begin
        case (cfg_log_op)
            `ISM_LOG_AND: log_d = pre_out[`ISM_DST_LOGA] & pre_out[`ISM_DST_LOGB];
            `ISM_LOG_OR: log_d = pre_out[`ISM_DST_LOGA] | pre_out[`ISM_DST_LOGB];
            `ISM_LOG_XOR: log_d = pre_out[`ISM_DST_LOGA] ^ pre_out[`ISM_DST_LOGB];
            default: log_d = ~(pre_out[`ISM_DST_LOGA] & pre_out[`ISM_DST_LOGB]);
        endcase
    end

    // registered outputs; one cycle latency from source
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dst_out <= '0;
            pin_od_oe_n <= 4'hF;
            log_res_q <= 1'b0;
            logic_result <= 1'b0;
        end else begin
            dst_out <= pre_out;
            pin_od_oe_n <= ~pre_out[3:0]; // open drain: low enable drives low level
            log_res_q <= log_d;
            logic_result <= log_d;
        end
    end

    // configuration state machine: load after reset, save on command
    ism_pkg::ism_state_e st_d;
    always_comb begin
        case (st_q)
            ism_pkg::ISM_ST_LOAD: st_d = nv_valid ? ism_pkg::ISM_ST_WAIT : ism_pkg::ISM_ST_RUN;
            ism_pkg::ISM_ST_WAIT: st_d = nv_rd_done ? ism_pkg::ISM_ST_RUN : ism_pkg::ISM_ST_WAIT;
            ism_pkg::ISM_ST_RUN: st_d = cmd_save ? ism_pkg::ISM_ST_SAVE : ism_pkg::ISM_ST_RUN;
            ism_pkg::ISM_ST_SAVE: st_d = nv_wr_done ? ism_pkg::ISM_ST_RUN : ism_pkg::ISM_ST_SAVE;
            default: st_d = ism_pkg::ISM_ST_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ism_pkg::ISM_ST_LOAD;
            nv_rd_req <= 1'b0;
            nv_wr_req <= 1'b0;
            cfg_busy <= 1'b1;
        end else begin
            st_q <= st_d;
            nv_rd_req <= (st_d == ism_pkg::ISM_ST_WAIT);
            nv_wr_req <= (st_d == ism_pkg::ISM_ST_SAVE);
            cfg_busy <= (st_d != ism_pkg::ISM_ST_RUN);
        end
    end

    // route table writes; default wins over port writes, and applies in the run state only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NDST; i++) begin
                route_q[i] <= '{sel: `ISM_DEF_SEL, opt: '0};
            end
            for (int i = 0; i < NSRC; i++) begin
                src_opt_q[i] <= '0;
            end
        end else if (cmd_default && st_q == ism_pkg::ISM_ST_RUN) begin
            for (int i = 0; i < NDST; i++) begin
                route_q[i] <= '{sel: `ISM_DEF_SEL, opt: '0};
            end
            for (int i = 0; i < NSRC; i++) begin
                src_opt_q[i] <= '0;
            end
        end else if (st_q == ism_pkg::ISM_ST_WAIT && nv_rd_done) begin
            for (int i = 0; i < NDST; i++) begin
                route_q[i] <= nv_rd_data[i];
            end
        end else if (st_q == ism_pkg::ISM_ST_RUN) begin
            if (cfg_we && cfg_dst < 5'(NDST)) begin
                route_q[cfg_dst] <= cfg_route;
            end
            if (cfg_src_we && cfg_src_idx < 5'(NSRC)) begin
                src_opt_q[cfg_src_idx] <= cfg_src_opt;
            end
        end
    end

    // snapshot presented to the store while saving
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nv_wr_data <= '0;
        end else if (st_q == ism_pkg::ISM_ST_RUN && cmd_save) begin
            for (int i = 0; i < NDST; i++) begin
                nv_wr_data[i] <= route_q[i];
            end
        end
    end

    // a save command raises the store request on the next cycle
    AST_SAVE_REQ: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q == ism_pkg::ISM_ST_RUN && cmd_save) |=> nv_wr_req)
        else $error("save not requested");
    AST_DEFAULT: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q == ism_pkg::ISM_ST_RUN && cmd_default) |=> route_q[0].sel == `ISM_DEF_SEL)
        else $error("default not restored");
    AST_LATENCY: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> dst_out == $past(pre_out))
        else $error("destination latency wrong");
    AST_FORCE: assert property (@(posedge mclk) disable iff (!arst_n)
        (route_q[0].opt.force_hi && !route_q[0].opt.inv) |=> dst_out[0])
        else $error("force high not applied");
    AST_FORCE_INV: assert property (@(posedge mclk) disable iff (!arst_n)
        (route_q[1].opt.force_hi && route_q[1].opt.inv) |=> !dst_out[1])
        else $error("inverted force not low");
    AST_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q == ism_pkg::ISM_ST_WAIT && nv_rd_done && !cmd_default)
        |=> route_q[2] == $past(nv_rd_data[2]))
        else $error("stored route not loaded");
    AST_LOGIC: assert property (@(posedge mclk) disable iff (!arst_n)
        (cfg_log_op == `ISM_LOG_AND) |=> logic_result ==
        ($past(pre_out[`ISM_DST_LOGA]) & $past(pre_out[`ISM_DST_LOGB])))
        else $error("logic and wrong");
    AST_OD: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> pin_od_oe_n[0] == !dst_out[0])
        else $error("open drain enable mismatch");

    // save handshake steps, shared by the save properties
    sequence seq_save_cmd;
        st_q == ism_pkg::ISM_ST_RUN && cmd_save;
    endsequence
    sequence seq_save_hold;
        nv_wr_req && cfg_busy;
    endsequence
    sequence seq_save_ack;
        st_q == ism_pkg::ISM_ST_SAVE && nv_wr_done;
    endsequence
    sequence seq_save_free;
        !nv_wr_req && !cfg_busy;
    endsequence

    // busy and store requests follow the state register exactly
    AST_BUSY: assert property (@(posedge mclk) disable iff (!arst_n)
        cfg_busy == (st_q != ism_pkg::ISM_ST_RUN))
        else $error("busy flag out of step");
    AST_RD_REQ: assert property (@(posedge mclk) disable iff (!arst_n)
        nv_rd_req == (st_q == ism_pkg::ISM_ST_WAIT))
        else $error("load request out of step");
    AST_WR_REQ: assert property (@(posedge mclk) disable iff (!arst_n)
        nv_wr_req == (st_q == ism_pkg::ISM_ST_SAVE))
        else $error("save request out of step");
    // load state lasts one cycle only
    AST_LOAD_EXIT: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q == ism_pkg::ISM_ST_LOAD |=> st_q != ism_pkg::ISM_ST_LOAD)
        else $error("load state stuck");
    // save raises the request and busy together
    AST_SAVE_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
        seq_save_cmd |=> seq_save_hold)
        else $error("save not held busy");
    // store acknowledge frees the block next cycle
    AST_SAVE_END: assert property (@(posedge mclk) disable iff (!arst_n)
        seq_save_ack |=> seq_save_free)
        else $error("save not released");
    // snapshot taken at the save command
    AST_SNAPSHOT: assert property (@(posedge mclk) disable iff (!arst_n)
        seq_save_cmd |=> nv_wr_data[0] == $past(route_q[0]))
        else $error("save snapshot wrong");
    // a route or source option write lands one cycle later
    AST_CFG_WR: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q == ism_pkg::ISM_ST_RUN && cfg_we && cfg_dst == 5'h00 && !cmd_default)
        |=> route_q[0] == $past(cfg_route))
        else $error("route write lost");
    AST_SRC_WR: assert property (@(posedge mclk) disable iff (!arst_n)
        (st_q == ism_pkg::ISM_ST_RUN && cfg_src_we && cfg_src_idx == 5'h00 && !cmd_default)
        |=> src_opt_q[0] == $past(cfg_src_opt))
        else $error("source option write lost");
    // writes while saving are refused
    AST_SAVE_FREEZE: assert property (@(posedge mclk) disable iff (!arst_n)
        st_q == ism_pkg::ISM_ST_SAVE |=> $stable(route_q[0]))
        else $error("route changed while saving");
    // synchroniser only moves when the last two stages agree
    AST_SYNC_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
        (s2_q[0] != s3_q[0]) |=> pin_q[0] == $past(pin_q[0]))
        else $error("pin moved before agreement");
    AST_SYNC_TAKE: assert property (@(posedge mclk) disable iff (!arst_n)
        (s2_q[0] == s3_q[0]) |=> pin_q[0] == $past(s3_q[0]))
        else $error("pin not taken after agreement");
    // remaining boolean operations
    AST_LOGIC_OR: assert property (@(posedge mclk) disable iff (!arst_n)
        (cfg_log_op == `ISM_LOG_OR) |=> logic_result ==
        ($past(pre_out[`ISM_DST_LOGA]) | $past(pre_out[`ISM_DST_LOGB])))
        else $error("logic or wrong");
    AST_LOGIC_XOR: assert property (@(posedge mclk) disable iff (!arst_n)
        (cfg_log_op == `ISM_LOG_XOR) |=> logic_result ==
        ($past(pre_out[`ISM_DST_LOGA]) ^ $past(pre_out[`ISM_DST_LOGB])))
        else $error("logic xor wrong");
    AST_LOGIC_NAND: assert property (@(posedge mclk) disable iff (!arst_n)
        (cfg_log_op == `ISM_LOG_NAND) |=> logic_result ==
        !($past(pre_out[`ISM_DST_LOGA]) & $past(pre_out[`ISM_DST_LOGB])))
        else $error("logic nand wrong");
    // empty select without options reads low
    AST_EMPTY_SEL: assert property (@(posedge mclk) disable iff (!arst_n)
        (!sel_ok[2] && route_q[2].opt == 2'h0) |=> !dst_out[2])
        else $error("empty select not low");
    // force high wins even over an empty select
    AST_EMPTY_FORCE: assert property (@(posedge mclk) disable iff (!arst_n)
        (!sel_ok[3] && route_q[3].opt.force_hi && !route_q[3].opt.inv) |=> dst_out[3])
        else $error("force lost on empty select");
    // derived logic source and result register agree
    AST_LOGIC_SRC: assert property (@(posedge mclk) disable iff (!arst_n)
        1'b1 |=> log_res_q == logic_result)
        else $error("logic source out of step");
endmodule : ism_switch_matrix

// file: tb/ism_nv_store_model.sv
// non-volatile routing store model for the switch matrix bench
`timescale 1ns/1ps
module ism_nv_store_model #(
    parameter int NDST = 18,
    parameter int DLY = 3 // done after DLY+1 request cycles
) (
    input wire logic mclk,
    input wire logic nv_rd_req,
    input wire logic nv_wr_req,
    input wire ism_pkg::ism_route_s [NDST-1:0] nv_wr_data,
    output logic nv_valid,
    output logic nv_rd_done,
    output logic nv_wr_done,
    output ism_pkg::ism_route_s [NDST-1:0] nv_rd_data
);
    ism_pkg::ism_route_s [NDST-1:0] mem_q = '0; // stored routing
    int cnt_q = 0; // cycles spent on a request
    initial begin
        nv_valid = 0;
        nv_rd_done = 0;
        nv_wr_done = 0;
    end
    // one request at a time; data is only true in the done cycle
    always @(posedge mclk) begin
        nv_rd_done <= 0;
        nv_wr_done <= 0;
        nv_rd_data <= ~mem_q; // bus released: never the stored value
        if ((nv_rd_req || nv_wr_req) && !nv_rd_done && !nv_wr_done) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q == DLY) begin
                cnt_q <= 0;
                if (nv_wr_req) begin
                    mem_q <= nv_wr_data;
                    nv_valid <= 1;
                    nv_wr_done <= 1;
                end else begin
                    nv_rd_data <= mem_q;
                    nv_rd_done <= 1;
                end
            end
        end
    end
endmodule : ism_nv_store_model

// file: tb/io_signal_switch_matrix_tb_top.sv
// self-checking bench for the io signal switch matrix
`timescale 1ns/1ps
module io_signal_switch_matrix_tb_top;
    logic mclk = 0, arst_n = 0, pin_rxd = 0, pin_mft_rxd = 0;
    logic cfg_we = 0, cfg_src_we = 0, cmd_default = 0, cmd_save = 0;
    logic [3:0] pin_trig_in = '0;
    logic [24:0] mod_src = '0;
    logic [4:0] cfg_dst = '0, cfg_src_idx = '0;
    logic [1:0] cfg_log_op = '0;
    ism_pkg::ism_route_s cfg_route = '0;
    ism_pkg::ism_lineopt_s cfg_src_opt = '0;
    ism_pkg::ism_route_s [17:0] nv_rd_data, nv_wr_data;
    logic nv_valid, nv_rd_done, nv_wr_done, nv_rd_req, nv_wr_req, logic_result, cfg_busy;
    logic [17:0] dst_out;
    logic [3:0] pin_od_oe_n;
    int errors = 0, checks = 0, cyc = 0;
    int src_tab[13] = '{6, 7, 20, 21, 8, 9, 13, 14, 12, 15, 18, 16, 17}; // module sources
    ism_switch_matrix ism_switch_matrix_i (.mclk, .arst_n, .pin_trig_in, .pin_rxd,
        .pin_mft_rxd, .mod_src, .cfg_we, .cfg_dst, .cfg_route, .cfg_src_idx, .cfg_src_opt,
        .cfg_src_we, .cfg_log_op, .cmd_default, .cmd_save, .nv_valid, .nv_rd_done,
        .nv_rd_data, .nv_rd_req, .nv_wr_req, .nv_wr_data, .nv_wr_done, .dst_out,
        .pin_od_oe_n, .logic_result, .cfg_busy);
    ism_nv_store_model ism_nv_store_model_i (.mclk, .nv_rd_req, .nv_wr_req, .nv_wr_data,
        .nv_valid, .nv_rd_done, .nv_wr_done, .nv_rd_data);
    // 40 MHz clock
    initial forever #12.5 mclk = ~mclk;
    // hang guard, far above the real run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // let n edges pass, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic route(input logic [4:0] d, input logic [4:0] s, input logic [1:0] o);
        @(posedge mclk);
        cfg_we <= 1;
        cfg_dst <= d;
        cfg_route <= {s, o};
        @(posedge mclk);
        cfg_we <= 0;
        tick(3);
    endtask : route
    task automatic set_src(input logic [4:0] s, input logic [1:0] o);
        @(posedge mclk);
        cfg_src_we <= 1;
        cfg_src_idx <= s;
        cfg_src_opt <= o;
        @(posedge mclk);
        cfg_src_we <= 0;
        tick(1);
    endtask : set_src
    // 2 cycles of reset, then wait for the load to finish
    task automatic do_reset;
        @(posedge mclk);
        arst_n <= 0;
        tick(2);
        arst_n <= 1;
        for (int i = 0; i < 200 && cfg_busy !== 1'b0; i++) tick(1);
    endtask : do_reset
    task automatic t_default;
        do_reset();
        pin_trig_in <= 4'h1;
        tick(8);
        chk("default routes", 18'h3FFFF, dst_out);
        chk("od enables", 18'h0, {14'h0, pin_od_oe_n});
        pin_trig_in <= 4'h0;
        tick(8);
    endtask : t_default
    // the 13 module sources in src_tab, each to its own destination, one hot
    task automatic t_sources;
        for (int i = 0; i < 13; i++) begin
            route(5'(i + 4), 5'(src_tab[i]), 2'h0);
            mod_src <= 25'h1 << src_tab[i];
            tick(3);
            chk("source map", 18'h1 << (i + 4), dst_out);
        end
    endtask : t_sources
    // inv/force_hi on destination 0 and inversion on source 6
    task automatic t_opts;
        for (int k = 0; k < 8; k++) begin
            mod_src <= 25'(k[2]) << 6;
            route(5'h0, 5'h6, 2'(k));
            chk("line option", {17'h0, k[0] ? ~k[1] : k[2] ^ k[1]}, {17'h0, dst_out[0]});
        end
        set_src(5'h06, 2'h2);
        route(5'h0, 5'h6, 2'h0);
        chk("source invert", 18'h0, {17'h0, dst_out[0]});
        set_src(5'h06, 2'h0);
        route(5'h0, 5'h1F, 2'h1);
        chk("force on empty select", 18'h1, {17'h0, dst_out[0]});
        route(5'h0, 5'h1F, 2'h0);
        chk("empty select", 18'h0, {17'h0, dst_out[0]});
    endtask : t_opts
    task automatic t_logic;
        logic e;
        route(5'hA, 5'h6, 2'h0);
        route(5'hB, 5'h7, 2'h0);
        route(5'h1, 5'h13, 2'h0);
        for (int k = 0; k < 16; k++) begin
            cfg_log_op <= 2'(k >> 2);
            mod_src <= 25'(k[1:0]) << 6;
            tick(5);
            e = k < 4 ? k[0] & k[1] : k < 8 ? k[0] | k[1] : k < 12 ? k[0] ^ k[1] : ~(k[0] & k[1]);
            chk("logic result", {17'h0, e}, {17'h0, logic_result});
            chk("logic source", {17'h0, e}, {17'h0, dst_out[1]});
        end
    endtask : t_logic
    task automatic t_persist;
        route(5'h3, 5'h6, 2'h0);
        mod_src <= 25'h1 << 6;
        @(posedge mclk);
        cmd_save <= 1;
        @(posedge mclk);
        cmd_save <= 0;
        tick(1);
        chk("save request", 18'h1, {17'h0, nv_wr_req});
        for (int i = 0; i < 200 && cfg_busy !== 1'b0; i++) tick(1);
        chk("store holds", 18'h1, {17'h0, nv_valid});
        @(posedge mclk);
        cmd_default <= 1;
        @(posedge mclk);
        cmd_default <= 0;
        tick(3);
        chk("factory route", 18'h0, {17'h0, dst_out[3]});
        do_reset();
        tick(3);
        chk("stored route", 18'h1, {17'h0, dst_out[3]});
    endtask : t_persist
    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        t_default();
        t_sources();
        t_opts();
        t_logic();
        t_persist();
        wrap_up();
    end
endmodule : io_signal_switch_matrix_tb_top
